/* File: design/sector_protect_control.v */
// serial command decode, global protect/unprotect, lock bit and protection read
`timescale 1ns/10ps
`include "sector_protect_defs.vh"
// Overview of operation
// - wp pin high with lock set: status write never changes protection bits
// - lock set with wp pin deasserted: status write may clear the lock bit
// - unlocked, writing 00h clears all protection bits, lock stays zero
// - unlocked, writing 7fh sets all protection bits, lock stays zero
// - unlocked, writing ffh sets all protection bits and sets lock
// - writing 0fh clears lock without global operation when wp deasserted
// - writing f0h sets lock leaving protection bits untouched
// - unlocked, bits 5..2 all ones protect all, all zeros unprotect, else none
// - bits 5..2 only decoded; only bit 7 stored; reads show wp and summary
// - read protection: opcode 3ch then three address bytes inside the sector
// - after address, serial out repeats ffh if protected, 00h if not
// - chip select release ends the read and floats serial out
// - protection read returns the stored bit only, never the wp pin
// - status shows whether all, some or none of sectors are protected
// - hardware lock when wp asserted and lock set ignores status writes
module sector_protect_control #(
  parameter SECTORS = 64,
  parameter SECT_BITS = 6,
  parameter ADDR_W = 24,
  parameter SECT_SHIFT = 16
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // serial bus pins, sampled through synchronisers
  input wire cs_n,
  input wire sck,
  input wire si,
  input wire wp_n,
  // serial out as output plus enable, enable low while driving
  output reg so_out,
  output reg so_oe_n,
  // write enable latch from the rest of the device
  input wire write_enable,
  // status view
  output reg lock_bit,
  output reg [1:0] soft_protect_summary,
  output reg [SECTORS-1:0] sector_protect,
  output reg [7:0] status_byte1
);
  localparam ST_OP = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_READ = 3'h3;
  localparam ST_SREAD = 3'h4;
  // unknown opcodes and bytes past the first data byte wait here for release
  localparam ST_IGNORE = 3'h5;

  ////////////////////////////////////////////////////////////////////////////////
  // synchronise pins; select and wp are turned active high before the flops
  wire [3:0] pin_raw = {~wp_n, si, sck, ~cs_n};
  wire [3:0] pin_s;
  wire cs_s = pin_s[0];
  wire sck_s = pin_s[1];
  wire si_s = pin_s[2];
  wire wp_s = pin_s[3];
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      sync2 u_sync (
        .clk(clk),
        .rstn(rstn),
        .d(pin_raw[gi]),
        .q(pin_s[gi])
      );
    end
  endgenerate

  // reset low matches the idle level of sck, so no false edge follows reset
  reg sck_d_r;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_d_r <= 1'b0;
    end else begin
      sck_d_r <= sck_s;
    end
  end
  // sck is slow against clk, so edges are found on the synchronised copy
  wire rise = cs_s & sck_s & ~sck_d_r;
  wire fall = cs_s & ~sck_s & sck_d_r;

  ////////////////////////////////////////////////////////////////////////////////
  // summary decode, used for the output and for the status byte
  function [1:0] summarise;
    input [SECTORS-1:0] p;
    begin
      if (&p) begin
        summarise = `SUMMARY_ALL;
      end else if (|p) begin
        summarise = `SUMMARY_SOME;
      end else begin
        summarise = `SUMMARY_NONE;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // shift engine and command state
  reg [2:0] state_r;
  reg [2:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg [7:0] opcode_r;
  reg [1:0] addr_cnt_r;
  reg [ADDR_W-1:0] addr_r;
  reg [7:0] wdata_r;
  reg wdata_full_r;
  reg cs_d_r;
  reg [7:0] out_byte_r;
  reg [2:0] out_idx_r;

  // shift in at the lsb so the first bit ends up at bit 7
  wire [7:0] byte_in = {shift_r[6:0], si_s};
  wire byte_done = rise & (bit_cnt_r == 3'h7);
  // release is seen two clk late, after the last sck edge has been taken
  wire cs_end = cs_d_r & ~cs_s;
  // hardware lock needs both the pin asserted and the lock bit set
  wire hw_locked = wp_s & lock_bit;
  // sector number from the address; the bits below it select nothing
  wire [SECT_BITS-1:0] sect_idx = addr_r[SECT_SHIFT +: SECT_BITS];
  wire [3:0] gfield = wdata_r[`GLOBAL_FIELD_HI:`GLOBAL_FIELD_LO];
  wire wlock = wdata_r[`LOCK_BIT_POS];

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_OP;
      bit_cnt_r <= 3'h0;
      shift_r <= 8'h00;
      opcode_r <= 8'h00;
      addr_cnt_r <= 2'h0;
      addr_r <= {ADDR_W{1'b0}};
      wdata_r <= 8'h00;
      wdata_full_r <= 1'b0;
      cs_d_r <= 1'b0;
    end else begin
      cs_d_r <= cs_s;
      if (!cs_s) begin
        state_r <= ST_OP;
        bit_cnt_r <= 3'h0;
        addr_cnt_r <= 2'h0;
        // the flag outlives release by one cycle so the commit still sees it
        if (!cs_d_r) begin
          wdata_full_r <= 1'b0;
        end
      end else if (rise) begin
        // si is taken on the sck rise, msb first
        bit_cnt_r <= bit_cnt_r + 3'h1;
        shift_r <= byte_in;
        if (byte_done) begin
          case (state_r)
            ST_OP: begin
              opcode_r <= byte_in;
              if (byte_in == `OP_READ_PROTECT) begin
                state_r <= ST_ADDR;
              end else if (byte_in == `OP_WRITE_STATUS1) begin
                state_r <= ST_DATA;
              end else if (byte_in == `OP_READ_STATUS) begin
                state_r <= ST_SREAD;
              end else begin
                state_r <= ST_IGNORE;
              end
            end
            ST_ADDR: begin
              addr_r <= {addr_r[ADDR_W-9:0], byte_in};
              addr_cnt_r <= addr_cnt_r + 2'h1;
              if (addr_cnt_r == `ADDR_LAST_BYTE) begin
                state_r <= ST_READ;
              end
            end
            // keep the first full byte only
            ST_DATA: begin
              wdata_r <= byte_in;
              wdata_full_r <= 1'b1;
              state_r <= ST_IGNORE;
            end
            // read and ignore states hold until release
            default: begin
              state_r <= state_r;
            end
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status write decision, applied once at chip select release
  wire wr_commit = cs_end & wdata_full_r & (opcode_r == `OP_WRITE_STATUS1) & write_enable;
  reg lock_nxt;
  reg set_all_nxt;
  reg clr_all_nxt;

  always @* begin
    lock_nxt = lock_bit;
    set_all_nxt = 1'b0;
    clr_all_nxt = 1'b0;
    if (wr_commit) begin
      if (hw_locked) begin
        lock_nxt = lock_bit;
      end else if (lock_bit) begin
        lock_nxt = wlock;
      end else begin
        // lock set with or without global
        lock_nxt = wlock;
        set_all_nxt = (gfield == `GLOBAL_PROTECT_CODE);
        clr_all_nxt = (gfield == `GLOBAL_UNPROTECT_CODE);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // protection bits and lock bit
  // the old lock value decides, so clearing it never also allows a global operation
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sector_protect <= {SECTORS{`PROTECT_RESET_VAL}};
      lock_bit <= `LOCK_RESET_VAL;
    end else begin
      lock_bit <= lock_nxt;
      if (set_all_nxt) begin
        sector_protect <= {SECTORS{1'b1}};
      end else if (clr_all_nxt) begin
        sector_protect <= {SECTORS{1'b0}};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // serial out; changes on the falling sck edge
  // a sector change during a read shows from the next byte boundary on
  wire [7:0] prot_byte = sector_protect[sect_idx] ? 8'hff : 8'h00;
  // bits 4..2 read back as wp pin and summary, not written data
  wire [7:0] stat_now = {lock_bit, 1'b0, 1'b0, wp_s, summarise(sector_protect), 2'h0};
  // in a protection read the source byte holds the stored bit only
  wire [7:0] src_byte = (state_r == ST_READ) ? prot_byte : stat_now;
  wire out_phase = (state_r == ST_READ) || (state_r == ST_SREAD);
  reg so_out_nxt;
  reg so_oe_n_nxt;
  reg [7:0] out_byte_nxt;
  reg [2:0] out_idx_nxt;

  always @* begin
    so_out_nxt = so_out;
    so_oe_n_nxt = so_oe_n;
    out_byte_nxt = out_byte_r;
    out_idx_nxt = out_idx_r;
    if (!cs_s) begin
      so_out_nxt = 1'b0;
      so_oe_n_nxt = 1'b1;
      out_idx_nxt = 3'h7;
    end else if (fall && out_phase) begin
      so_oe_n_nxt = 1'b0;
      out_idx_nxt = out_idx_r - 3'h1;
      if (out_idx_r == 3'h7) begin
        // byte reloads each time, so it repeats
        out_byte_nxt = src_byte;
        so_out_nxt = src_byte[7];
      end else begin
        so_out_nxt = out_byte_r[out_idx_r];
      end
    end
  end

  // registered so the pin never glitches with the decode
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      so_out <= 1'b0;
      so_oe_n <= 1'b1;
      out_byte_r <= 8'h00;
      out_idx_r <= 3'h7;
    end else begin
      so_out <= so_out_nxt;
      so_oe_n <= so_oe_n_nxt;
      out_byte_r <= out_byte_nxt;
      out_idx_r <= out_idx_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status outputs
  // bits 6, 5, 1 and 0 of the status byte read zero in this block
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      soft_protect_summary <= `SUMMARY_NONE;
      status_byte1 <= 8'h00;
    end else begin
      soft_protect_summary <= summarise(sector_protect);
      status_byte1 <= stat_now;
    end
  end
endmodule

/* File: design/sector_protect_defs.vh */
// constants for the sector protection control block
`ifndef SECTOR_PROTECT_DEFS_VH
`define SECTOR_PROTECT_DEFS_VH
`define OP_WRITE_STATUS1 8'h01
`define OP_READ_PROTECT 8'h3c
`define OP_READ_STATUS 8'h05
`define LOCK_BIT_POS 7
`define GLOBAL_FIELD_HI 5
`define GLOBAL_FIELD_LO 2
`define GLOBAL_PROTECT_CODE 4'hf
`define GLOBAL_UNPROTECT_CODE 4'h0
`define SUMMARY_NONE 2'h0
`define SUMMARY_SOME 2'h1
`define SUMMARY_ALL 2'h3
`define PROTECT_RESET_VAL 1'h1
`define LOCK_RESET_VAL 1'h0
// index of the last of the three address bytes
`define ADDR_LAST_BYTE 2'h2
`endif

/* File: design/sync2.v */
// two flip-flop synchroniser for one level
`timescale 1ns/10ps
module sync2 (
  // clock and reset
  input wire clk,
  input wire rstn,
  // level in and out
  input wire d,
  output reg q
);
  reg meta_r;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

/* File: testbench/sector_protect_chk.sv */
// port checker for the sector protection control block
`timescale 1ns/10ps
module sector_protect_chk #(
  parameter SECTORS = 64
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // pins
  input wire cs_n,
  input wire wp_n,
  input wire so_oe_n,
  // status view
  input wire lock_bit,
  input wire [1:0] soft_protect_summary,
  input wire [SECTORS-1:0] sector_protect,
  input wire [7:0] status_byte1
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence cs_idle; cs_n [*8]; endsequence
  sequence cs_busy; !cs_n [*6]; endsequence
  // synchroniser lag is why the wp level must settle first
  sequence hw_locked; (!wp_n && lock_bit) [*6]; endsequence
  AST_SO_FLOAT: assert property (cs_idle |-> so_oe_n)
    else $error("serial out driven while deselected");
  AST_HW_HOLD: assert property (hw_locked |=> $stable(sector_protect) && lock_bit)
    else $error("protection changed while hardware locked");
  AST_SP_BUSY: assert property (cs_busy |=> $stable(sector_protect))
    else $error("protection changed inside a command");
  AST_LOCK_BUSY: assert property (cs_busy |=> $stable(lock_bit))
    else $error("lock changed inside a command");
  AST_SUM_ALL: assert property ($stable(sector_protect) && &sector_protect
    |=> soft_protect_summary == 2'h3)
    else $error("summary not all");
  AST_SUM_NONE: assert property ($stable(sector_protect) && sector_protect == '0
    |=> soft_protect_summary == 2'h0)
    else $error("summary not none");
  AST_STAT_LOCK: assert property ($stable(lock_bit) |-> status_byte1[7] == lock_bit)
    else $error("status lock bit wrong");
  AST_STAT_SUM: assert property (&sector_protect |=> status_byte1[3:2] == 2'h3)
    else $error("status summary wrong");
  AST_STAT_WP: assert property (!wp_n [*6] |-> status_byte1[4])
    else $error("status wp bit wrong");
endmodule
bind sector_protect_control sector_protect_chk #(.SECTORS(SECTORS)) chk (.clk(clk),
  .rstn(rstn), .cs_n(cs_n), .wp_n(wp_n), .so_oe_n(so_oe_n), .lock_bit(lock_bit),
  .soft_protect_summary(soft_protect_summary), .sector_protect(sector_protect),
  .status_byte1(status_byte1));

/* File: testbench/host_model.sv */
// host controller model driving the serial bus
`timescale 1ns/10ps
module host_model (
  // clock
  input wire clk,
  // serial bus
  output reg cs_n,
  output reg sck,
  output reg si,
  input wire so_out,
  input wire so_oe_n
);
  // no pull on the line, so a float shows as z
  wire so = so_oe_n ? 1'bz : so_out;
  initial begin cs_n = 1'b1; sck = 1'b0; si = 1'b0; end
  task tick; begin @(posedge clk); #1; end endtask
  task half; begin repeat (4) tick; end endtask
  task xfer(input [7:0] tx, input integer n, output [7:0] rx);
    integer i;
    begin
      rx = 8'h00;
      for (i = 7; i > 7 - n; i--) begin
        si = tx[i]; half; sck = 1'b1; half; rx[i] = so; sck = 1'b0;
      end
    end
  endtask
  task start; begin cs_n = 1'b0; half; end endtask
  // sck stays low and si flips once released
  task stop; begin half; cs_n = 1'b1; si = ~si; repeat (10) tick; end endtask
endmodule

/* File: testbench/sector_protect_control_tb.sv */
// self-checking bench for the sector protection control block
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module sector_protect_control_tb;
  localparam [63:0] ALL = {64{1'b1}};
  reg clk, rstn, wp_n, write_enable;
  wire cs_n, sck, si, so_out, so_oe_n, lock_bit;
  wire [1:0] soft_protect_summary;
  wire [63:0] sector_protect;
  wire [7:0] status_byte1;
  integer mismatches = 0, samples_checked = 0;
  sector_protect_control dut (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sck(sck), .si(si),
    .wp_n(wp_n), .so_out(so_out), .so_oe_n(so_oe_n), .write_enable(write_enable),
    .lock_bit(lock_bit), .soft_protect_summary(soft_protect_summary),
    .sector_protect(sector_protect), .status_byte1(status_byte1));
  host_model host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so_out(so_out),
    .so_oe_n(so_oe_n));
  initial begin clk = 1'b0; forever #10 clk = ~clk; end
  task complete_run; begin
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end endtask
  task wr(input [7:0] d, input integer n); reg [7:0] r; begin
    host.start; host.xfer(8'h01, 8, r); host.xfer(d, n, r); host.stop;
  end endtask
  task st(input l, input [63:0] sp); reg [1:0] s; begin
    s = (&sp) ? 2'h3 : ((|sp) ? 2'h1 : 2'h0);
    `CHK(lock_bit, l)
    `CHK(sector_protect, sp)
    `CHK(soft_protect_summary, s)
    `CHK(status_byte1, {l, 2'h0, ~wp_n, s, 2'h0})
  end endtask
  task rd(input [7:0] sec, input [7:0] exp); reg [7:0] r; begin
    host.start; host.xfer(8'h3c, 8, r); host.xfer(8'h00, 8, r);
    host.xfer(sec, 8, r); host.xfer(8'h5a, 8, r);
    host.xfer(8'h00, 8, r); `CHK(r, exp)
    host.xfer(8'h00, 8, r); `CHK(r, exp)
    host.xfer(8'h00, 3, r); host.stop; `CHK(so_oe_n, 1'b1)
  end endtask
  task rs(input [7:0] exp); reg [7:0] r; begin
    host.start; host.xfer(8'h05, 8, r);
    host.xfer(8'h00, 8, r); `CHK(r, exp)
    host.xfer(8'h00, 8, r); `CHK(r, exp)
    host.stop;
  end endtask
  task t_global; begin
    wr(8'h00, 8); st(1'b0, 64'h0);
    rd(8'h3f, 8'h00);
    wr(8'h38, 8); st(1'b0, 64'h0);
    wr(8'h7f, 8); st(1'b0, ALL);
    wr(8'h00, 8); wr(8'h3c, 8); st(1'b0, ALL);
  end endtask
  task t_lock; begin
    wr(8'h00, 8); wr(8'hf0, 8); st(1'b1, 64'h0);
    wr(8'h7f, 8); st(1'b0, 64'h0);
    wr(8'h7f, 8); st(1'b0, ALL);
    wr(8'hf0, 8); wr(8'h0f, 8); st(1'b0, ALL);
    wr(8'h00, 8); wr(8'hff, 8); st(1'b1, ALL);
  end endtask
  task t_hw; begin
    wp_n = 1'b0; host.half;
    wr(8'h00, 8); st(1'b1, ALL);
    wr(8'h0f, 8); st(1'b1, ALL);
    rs(8'h9c);
    rd(8'h10, 8'hff);
    wp_n = 1'b1; host.half;
    wr(8'h0f, 8); st(1'b0, ALL);
  end endtask
  task t_refuse; begin
    wr(8'h00, 4); st(1'b0, ALL);
    write_enable = 1'b0; wr(8'h00, 8); st(1'b0, ALL);
    write_enable = 1'b1;
  end endtask
  initial begin
    #400000; mismatches++; complete_run;
  end
  initial begin
    rstn = 1'b0; wp_n = 1'b1; write_enable = 1'b1;
    repeat (6) @(posedge clk);
    #1 rstn = 1'b1;
    host.half;
    st(1'b0, ALL);
    rs(8'h0c);
    rd(8'h05, 8'hff);
    t_global; t_lock; t_hw; t_refuse;
    complete_run;
  end
endmodule
